// File: inc/spc_pkg.sv
// shared constants and types for the stream pattern checker
`default_nettype none
package spc_pkg;
  localparam int SYM_W = 8;
  localparam int SYMS = 4;
  localparam int DATA_W = 32;
  localparam int EMPTY_W = 2;
  localparam int CHANS = 4;
  localparam int CH_W = 2;
  localparam int ERR_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic FRAMING = 1'b1;
  // arbitrary identity value
  localparam logic [15:0] CORE_ID = 16'h5a3c;
  localparam logic [2:0] OFF_STATUS = 3'h0;
  localparam logic [2:0] OFF_CONTROL = 3'h1;
  localparam logic [2:0] OFF_FAULT = 3'h5;
  localparam logic [2:0] OFF_SELECT = 3'h6;
  localparam logic [2:0] OFF_TALLY = 3'h7;
  localparam logic OFF_SEG = 1'b0;
  localparam logic OFF_INJ = 1'b1;
  localparam int CTL_EN = 0;
  localparam int THR_LSB = 8;
  localparam int THR_MSB = 16;
  localparam int CTL_SRST = 17;
  localparam logic [8:0] THR_FULL = 9'h100;
  localparam logic [31:0] CTL_RST = 32'h0001_0000;
  localparam logic [7:0] LFSR_SEED = 8'h5b;
  localparam int INJ_MASK_LSB = 16;
  localparam int INJ_HIDE_SOP = 24;
  localparam int INJ_HIDE_EOP = 25;
  localparam int SEG_CH_LSB = 16;
  localparam int SEG_SOP = 30;
  localparam int SEG_EOP = 31;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [CH_W-1:0] ch;
    logic sop;
    logic eop;
    logic [EMPTY_W-1:0] empty;
    logic [ERR_W-1:0] err;
  } spc_beat_t;
  typedef struct packed {
    logic [7:0] ch;
    logic [7:0] rsvd1;
    logic [7:0] err;
    logic [6:0] rsvd0;
    logic data_err;
  } spc_fault_t;
endpackage
`default_nettype wire

// File: logic/spc_checker.sv
// stream pattern checker with generator fault injection and input fifo
// Operation
// - generator drives injected error value
// - generator xors data with corruption mask
// - hide start flag drops startofpacket
// - hide end flag drops endofpacket
// - register map at word offsets 0,1,5,6,7
// - status low half holds identity code
// - status shows channels, symbols, framing flag
// - accept data only while enabled
// - throttle gates acceptance against pseudorandom number
// - soft reset bit holds counters cleared
// - fault word reads zero when idle
// - fault bit 0 flags payload mismatch
// - fault bits 15:8 hold error value
// - fault bits 31:24 hold channel
// - select field picks channel for counters
// - select high half shows error count
// - tally low half shows packet count
// - tally high half shows symbol count
// - generator soft reset clears pending command, output valid only
// - segment word write pushes command
// - error input width fixed build constant
`timescale 1ns/1ps
`default_nettype none

module spc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic clr_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  // depth needs the counter's extra bit; AW bits alone would wrap it to 0
  assign in_ready_o = (cnt_reg != (AW+1)'(D)) && !clr_i;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rd_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (clr_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // spc_fifo

module spc_checker
  import spc_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic [2:0] CSR_ADDR_I,
  input wire logic CSR_RD_I,
  input wire logic CSR_WR_I,
  input wire logic [31:0] CSR_WDATA_I,
  output logic [31:0] CSR_RDATA_O,
  input wire logic CMD_ADDR_I,
  input wire logic CMD_WR_I,
  input wire logic CMD_RD_I,
  input wire logic [31:0] CMD_WDATA_I,
  output logic [31:0] CMD_RDATA_O,
  output logic CMD_BUSY_O,
  input wire logic GEN_SOFT_RESET_I,
  input wire logic SRC_VALID_I,
  input wire logic [DATA_W-1:0] SRC_DATA_I,
  output logic SRC_READY_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  output logic [DATA_W-1:0] TX_DATA_O,
  output logic [13:0] TX_CHANNEL_O,
  output logic TX_SOP_O,
  output logic TX_EOP_O,
  output logic [15:0] TX_ERROR_O,
  input wire logic RX_VALID_I,
  output logic RX_READY_O,
  input wire logic [DATA_W-1:0] RX_DATA_I,
  input wire logic [CH_W-1:0] RX_CHANNEL_I,
  input wire logic RX_SOP_I,
  input wire logic RX_EOP_I,
  input wire logic [EMPTY_W-1:0] RX_EMPTY_I,
  input wire logic [ERR_W-1:0] RX_ERROR_I
);
  // ---------------- generator fault injection ----------------
  logic [31:0] inj_reg;
  logic [31:0] generator_segment_word_reg;
  logic [31:0] generator_fault_injection_word_reg;
  logic cmd_valid_reg;
  logic [15:0] left_reg;
  logic first_reg;
  logic tx_valid_reg;
  logic src_fire;
  logic seg_last;
  logic [DATA_W-1:0] mask_word;

  assign CMD_BUSY_O = cmd_valid_reg;
  assign SRC_READY_O = cmd_valid_reg && (!tx_valid_reg || TX_READY_I);
  assign src_fire = SRC_VALID_I && SRC_READY_O;
  assign seg_last = (left_reg <= 16'(SYMS));
  assign mask_word = {SYMS{generator_fault_injection_word_reg[INJ_MASK_LSB +: SYM_W]}};
  assign TX_VALID_O = tx_valid_reg;

  // injection fields are control state, untouched by soft reset
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      inj_reg <= '0;
    end else if (CMD_WR_I && CMD_ADDR_I == OFF_INJ) begin
      inj_reg <= CMD_WDATA_I;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cmd_valid_reg <= 1'b0;
      generator_segment_word_reg <= '0;
      generator_fault_injection_word_reg <= '0;
      left_reg <= '0;
      first_reg <= 1'b0;
    end else if (GEN_SOFT_RESET_I) begin
      cmd_valid_reg <= 1'b0;
      left_reg <= '0;
      first_reg <= 1'b0;
    end else if (!cmd_valid_reg) begin
      if (CMD_WR_I && CMD_ADDR_I == OFF_SEG) begin
        cmd_valid_reg <= 1'b1;
        generator_segment_word_reg <= CMD_WDATA_I;
        generator_fault_injection_word_reg <= inj_reg;
        left_reg <= CMD_WDATA_I[15:0];
        first_reg <= 1'b1;
      end
    end else if (src_fire) begin
      first_reg <= 1'b0;
      left_reg <= seg_last ? 16'h0000 : left_reg - 16'(SYMS);
      cmd_valid_reg <= !seg_last;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_valid_reg <= 1'b0;
      TX_DATA_O <= '0;
      TX_CHANNEL_O <= '0;
      TX_SOP_O <= 1'b0;
      TX_EOP_O <= 1'b0;
      TX_ERROR_O <= '0;
    end else if (GEN_SOFT_RESET_I) begin
      tx_valid_reg <= 1'b0;
    end else if (src_fire) begin
      tx_valid_reg <= 1'b1;
      TX_DATA_O <= SRC_DATA_I ^ mask_word;
      TX_CHANNEL_O <= generator_segment_word_reg[SEG_CH_LSB +: 14];
      TX_SOP_O <= FRAMING && first_reg && generator_segment_word_reg[SEG_SOP]
        && !generator_fault_injection_word_reg[INJ_HIDE_SOP];
      TX_EOP_O <= FRAMING && seg_last && generator_segment_word_reg[SEG_EOP]
        && !generator_fault_injection_word_reg[INJ_HIDE_EOP];
      TX_ERROR_O <= generator_fault_injection_word_reg[15:0];
    end else if (TX_READY_I) begin
      tx_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CMD_RDATA_O <= '0;
    end else if (CMD_RD_I) begin
      CMD_RDATA_O <= (CMD_ADDR_I == OFF_INJ) ? inj_reg : generator_segment_word_reg;
    end
  end

  // ---------------- checker control ----------------
  logic [31:0] ctl_reg;
  logic [7:0] sel_reg;
  logic [7:0] lfsr_reg;
  logic srst;
  logic [8:0] thr;
  logic take;
  logic csr_wr_ctl;

  assign srst = ctl_reg[CTL_SRST];
  assign thr = ctl_reg[THR_MSB:THR_LSB];
  assign csr_wr_ctl = CSR_WR_I && CSR_ADDR_I == OFF_CONTROL;

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctl_reg <= CTL_RST;
    end else if (csr_wr_ctl) begin
      ctl_reg <= CSR_WDATA_I & 32'h0003_ff01;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sel_reg <= '0;
    end else if (CSR_WR_I && CSR_ADDR_I == OFF_SELECT) begin
      sel_reg <= CSR_WDATA_I[7:0];
    end
  end

  // free-running so the throttle pattern never waits on traffic
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      lfsr_reg <= LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[6:0],
        lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end
  end

  // ---------------- input fifo ----------------
  spc_beat_t rx_beat;
  spc_beat_t fb;
  logic fb_valid;

  assign rx_beat = '{data: RX_DATA_I, ch: RX_CHANNEL_I, sop: RX_SOP_I,
    eop: RX_EOP_I, empty: RX_EMPTY_I, err: RX_ERROR_I};
  // full rate bypasses the lfsr, whose largest value is 255
  assign take = fb_valid && ctl_reg[CTL_EN] && !srst
    && (thr >= THR_FULL || {1'b0, lfsr_reg} < thr);

  spc_fifo #(.W($bits(spc_beat_t)), .D(FIFO_DEPTH)) u_fifo (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .clr_i(srst),
    .in_valid_i(RX_VALID_I),
    .in_ready_o(RX_READY_O),
    .in_data_i(rx_beat),
    .out_valid_o(fb_valid),
    .out_ready_i(take),
    .out_data_o(fb)
  );

  // ---------------- per-channel checking ----------------
  logic [CHANS-1:0] mism;
  logic [15:0] pkt_cnt [CHANS];
  logic [15:0] sym_cnt [CHANS];
  logic [15:0] err_cnt [CHANS];
  logic [SYMS-1:0] valid_lane;
  logic [2:0] nsym;

  assign nsym = 3'(SYMS) - (fb.eop ? 3'(fb.empty) : 3'h0);

  genvar g;
  generate
    for (g = 0; g < SYMS; g++) begin : g_lane
      assign valid_lane[g] = (g < nsym);
    end
    for (g = 0; g < CHANS; g++) begin : g_ch
      logic [SYM_W-1:0] exp_reg;
      logic [SYMS-1:0] bad;
      logic hit;
      assign hit = take && fb.ch == CH_W'(g);
      for (genvar s = 0; s < SYMS; s++) begin : g_s
        assign bad[s] = valid_lane[s] &&
          fb.data[DATA_W-1-s*SYM_W -: SYM_W] != exp_reg + SYM_W'(s);
      end
      assign mism[g] = hit && |bad;
      always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
          exp_reg <= '0;
          pkt_cnt[g] <= '0;
          sym_cnt[g] <= '0;
          err_cnt[g] <= '0;
        end else if (srst) begin
          exp_reg <= '0;
          pkt_cnt[g] <= '0;
          sym_cnt[g] <= '0;
          err_cnt[g] <= '0;
        end else if (hit) begin
          // resync to the received first symbol so one fault counts once
          exp_reg <= fb.data[DATA_W-1 -: SYM_W] + SYM_W'(nsym);
          pkt_cnt[g] <= pkt_cnt[g] + 16'(fb.eop && FRAMING);
          sym_cnt[g] <= sym_cnt[g] + 16'(nsym);
          err_cnt[g] <= err_cnt[g] + 16'(|bad);
        end
      end
    end
  endgenerate

  // ---------------- exception holding ----------------
  spc_fault_t fault_reg;
  logic fault_pend_reg;
  logic new_fault;
  logic rd_fault;

  assign new_fault = take && (|mism || fb.err != '0);
  assign rd_fault = CSR_RD_I && CSR_ADDR_I == OFF_FAULT;

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      fault_pend_reg <= 1'b0;
      fault_reg <= '0;
    end else if (srst) begin
      fault_pend_reg <= 1'b0;
      fault_reg <= '0;
    end else if (new_fault && (!fault_pend_reg || rd_fault)) begin
      fault_pend_reg <= 1'b1;
      fault_reg <= '0;
      fault_reg.data_err <= |mism;
      fault_reg.err <= 8'(fb.err);
      fault_reg.ch <= 8'(fb.ch);
    end else if (rd_fault) begin
      fault_pend_reg <= 1'b0;
      fault_reg <= '0;
    end
  end

  // ---------------- register read ----------------
  logic [CH_W-1:0] sel_ch;
  logic sel_ok;
  assign sel_ch = sel_reg[CH_W-1:0];
  assign sel_ok = (sel_reg < 8'(CHANS));

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CSR_RDATA_O <= '0;
    end else if (CSR_RD_I) begin
      case (CSR_ADDR_I)
        OFF_STATUS: CSR_RDATA_O <= {FRAMING, 7'(SYMS), 8'(CHANS),
          CORE_ID};
        OFF_CONTROL: CSR_RDATA_O <= ctl_reg;
        OFF_FAULT: CSR_RDATA_O <= fault_reg;
        OFF_SELECT: CSR_RDATA_O <= {sel_ok ? err_cnt[sel_ch] : 16'h0000,
          8'h00, sel_reg};
        OFF_TALLY: CSR_RDATA_O <= sel_ok ?
          {sym_cnt[sel_ch], pkt_cnt[sel_ch]} : 32'h0000_0000;
        default: CSR_RDATA_O <= '0;
      endcase
    end
  end
endmodule // spc_checker

`default_nettype wire

// File: test/spc_checker_properties.sv
// port-level checks of the stream pattern checker
`timescale 1ns/1ps
`default_nettype none
module spc_checker_props
  import spc_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  input wire logic [2:0] CSR_ADDR_I,
  input wire logic CSR_RD_I,
  input wire logic CSR_WR_I,
  input wire logic [31:0] CSR_WDATA_I,
  input wire logic [31:0] CSR_RDATA_O,
  input wire logic CMD_ADDR_I,
  input wire logic CMD_WR_I,
  input wire logic [31:0] CMD_WDATA_I,
  input wire logic CMD_BUSY_O,
  input wire logic RX_READY_O,
  input wire logic TX_VALID_O,
  input wire logic TX_SOP_O,
  input wire logic TX_EOP_O,
  input wire logic [15:0] TX_ERROR_O
);
  logic [31:0] ctl_reg;
  logic [31:0] inj_reg;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctl_reg <= CTL_RST;
    end else if (CSR_WR_I && CSR_ADDR_I == OFF_CONTROL) begin
      ctl_reg <= CSR_WDATA_I & 32'h0003_ff01;
    end
  end
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      inj_reg <= 32'h0;
    end else if (CMD_WR_I && CMD_ADDR_I == OFF_INJ) begin
      inj_reg <= CMD_WDATA_I;
    end
  end
  sequence s_rd(a);
    CSR_RD_I && CSR_ADDR_I == a;
  endsequence
  sequence s_push;
    CMD_WR_I && CMD_ADDR_I == OFF_SEG && !CMD_BUSY_O;
  endsequence
  property p_status;
    s_rd(OFF_STATUS) |=>
      CSR_RDATA_O == {FRAMING, 7'(SYMS), 8'(CHANS), CORE_ID};
  endproperty
  a_status: assert property (p_status) else $error("status bad");
  property p_unmapped;
    CSR_RD_I && CSR_ADDR_I inside {[3'h2:3'h4]} |=> CSR_RDATA_O == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole");
  property p_ctl;
    s_rd(OFF_CONTROL) |=> CSR_RDATA_O == $past(ctl_reg);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control bad");
  property p_srst;
    ctl_reg[CTL_SRST] |-> !RX_READY_O;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset");
  property p_sop;
    TX_VALID_O && inj_reg[INJ_HIDE_SOP] |-> !TX_SOP_O;
  endproperty
  a_sop: assert property (p_sop) else $error("start shown");
  property p_eop;
    TX_VALID_O && inj_reg[INJ_HIDE_EOP] |-> !TX_EOP_O;
  endproperty
  a_eop: assert property (p_eop) else $error("end shown");
  property p_err;
    TX_VALID_O |-> TX_ERROR_O == inj_reg[15:0];
  endproperty
  a_err: assert property (p_err) else $error("error value");
  property p_push;
    s_push |=> CMD_BUSY_O;
  endproperty
  a_push: assert property (p_push) else $error("no push");
endmodule // spc_checker_props
bind spc_checker spc_checker_props u_props (.REF_CLK_I(REF_CLK_I),
  .ARST_N_I(ARST_N_I), .CSR_ADDR_I(CSR_ADDR_I), .CSR_RD_I(CSR_RD_I),
  .CSR_WR_I(CSR_WR_I), .CSR_WDATA_I(CSR_WDATA_I),
  .CSR_RDATA_O(CSR_RDATA_O), .CMD_ADDR_I(CMD_ADDR_I),
  .CMD_WR_I(CMD_WR_I), .CMD_WDATA_I(CMD_WDATA_I),
  .CMD_BUSY_O(CMD_BUSY_O), .RX_READY_O(RX_READY_O),
  .TX_VALID_O(TX_VALID_O), .TX_SOP_O(TX_SOP_O), .TX_EOP_O(TX_EOP_O),
  .TX_ERROR_O(TX_ERROR_O));
`default_nettype wire

// File: test/spc_src_model.sv
// stream source feeding the checker and stalling sink for tx
`timescale 1ns/1ps
`default_nettype none
module spc_src_model
  import spc_pkg::*;
(
  input wire logic clk_i,
  input wire logic ready_i,
  output var spc_beat_t beat_o,
  output logic valid_o,
  output logic tx_ready_o
);
  initial begin
    beat_o = '0;
    valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // stalls about one cycle in four
  always @(posedge clk_i) tx_ready_o <= #1 ($urandom_range(3) != 0);
  // beat held until taken or 64 cycles pass, then lines show the inverse
  task automatic send(input spc_beat_t b, output bit ok);
    int n;
    beat_o = b;
    valid_o = 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ready_i && n < 64);
    ok = ready_i;
    #1 valid_o = 1'b0;
    beat_o = ~b;
  endtask
endmodule // spc_src_model
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the stream pattern checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spc_pkg::*;
  localparam logic [31:0] ST = {FRAMING, 7'(SYMS), 8'(CHANS), CORE_ID};
  logic REF_CLK_I, ARST_N_I, CSR_RD_I, CSR_WR_I, CMD_ADDR_I, CMD_WR_I;
  logic CMD_RD_I, GEN_SOFT_RESET_I, SRC_VALID_I, TX_VALID_O, TX_READY_I;
  logic CMD_BUSY_O, SRC_READY_O, TX_SOP_O, TX_EOP_O, RX_VALID_I, RX_READY_O;
  logic [2:0] CSR_ADDR_I;
  logic [31:0] CSR_WDATA_I, CSR_RDATA_O, CMD_WDATA_I, CMD_RDATA_O;
  logic [31:0] SRC_DATA_I, TX_DATA_O;
  logic [13:0] TX_CHANNEL_O;
  logic [15:0] TX_ERROR_O;
  spc_beat_t rx;
  logic [63:0] rq[$], tq[$];
  logic rd_pend = 1'b0;
  logic rd_cmd = 1'b0;
  int mismatches, n_tests;
  spc_checker DUT (.REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I),
    .CSR_ADDR_I(CSR_ADDR_I), .CSR_RD_I(CSR_RD_I), .CSR_WR_I(CSR_WR_I),
    .CSR_WDATA_I(CSR_WDATA_I), .CSR_RDATA_O(CSR_RDATA_O),
    .CMD_ADDR_I(CMD_ADDR_I), .CMD_WR_I(CMD_WR_I), .CMD_RD_I(CMD_RD_I),
    .CMD_WDATA_I(CMD_WDATA_I), .CMD_RDATA_O(CMD_RDATA_O),
    .CMD_BUSY_O(CMD_BUSY_O), .GEN_SOFT_RESET_I(GEN_SOFT_RESET_I),
    .SRC_VALID_I(SRC_VALID_I), .SRC_DATA_I(SRC_DATA_I),
    .SRC_READY_O(SRC_READY_O), .TX_VALID_O(TX_VALID_O),
    .TX_READY_I(TX_READY_I), .TX_DATA_O(TX_DATA_O),
    .TX_CHANNEL_O(TX_CHANNEL_O), .TX_SOP_O(TX_SOP_O), .TX_EOP_O(TX_EOP_O),
    .TX_ERROR_O(TX_ERROR_O), .RX_VALID_I(RX_VALID_I),
    .RX_READY_O(RX_READY_O), .RX_DATA_I(rx.data), .RX_CHANNEL_I(rx.ch),
    .RX_SOP_I(rx.sop), .RX_EOP_I(rx.eop), .RX_EMPTY_I(rx.empty),
    .RX_ERROR_I(rx.err));
  spc_src_model src (.clk_i(REF_CLK_I), .ready_i(RX_READY_O), .beat_o(rx),
    .valid_o(RX_VALID_I), .tx_ready_o(TX_READY_I));
  initial begin
    REF_CLK_I = 1'b0;
    forever #5 REF_CLK_I = ~REF_CLK_I;
  end
  task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic lim(int n);
    if (n >= 64) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic tick;
    @(posedge REF_CLK_I);
    #1;
  endtask
  // reads note the expected word, writes just land
  task automatic csr(logic [2:0] a, logic wr, logic [31:0] d);
    CSR_ADDR_I = a;
    CSR_WDATA_I = d;
    CSR_WR_I = wr;
    CSR_RD_I = !wr;
    if (!wr) rq.push_back(64'(d));
    tick();
    {CSR_WR_I, CSR_RD_I} = 2'b00;
    tick();
  endtask
  task automatic cmd(logic a, logic wr, logic [31:0] d);
    CMD_ADDR_I = a;
    CMD_WDATA_I = d;
    CMD_WR_I = wr;
    CMD_RD_I = !wr;
    if (!wr) rq.push_back(64'(d));
    tick();
    {CMD_WR_I, CMD_RD_I} = 2'b00;
    tick();
  endtask
  task automatic put(logic [31:0] d, logic [1:0] c, logic [1:0] f,
                     logic [7:0] e);
    bit ok;
    src.send('{d, c, f[1], f[0], 2'h0, e}, ok);
    lim(ok ? 0 : 64);
    repeat (6) tick();
  endtask
  task automatic rpt(string s);
    $display("test %s done, checks %0d, mismatches %0d", s, n_tests,
             mismatches);
  endtask
  always @(posedge REF_CLK_I) begin
    if (rd_pend) chk("read", rq.pop_front(),
                     64'(rd_cmd ? CMD_RDATA_O : CSR_RDATA_O));
    rd_pend = CSR_RD_I | CMD_RD_I;
    rd_cmd = CMD_RD_I;
  end
  always @(posedge REF_CLK_I) begin
    if (TX_VALID_O && TX_READY_I) chk("tx", tq.size() ? tq.pop_front() : '1,
      {TX_DATA_O, TX_SOP_O, TX_EOP_O, TX_ERROR_O, TX_CHANNEL_O});
  end
  initial begin
    logic [31:0] inj, d;
    logic [7:0] r;
    int n;
    bit ok;
    {ARST_N_I, CSR_RD_I, CSR_WR_I, CMD_RD_I, CMD_WR_I, CMD_ADDR_I} = '0;
    {CSR_ADDR_I, CSR_WDATA_I, CMD_WDATA_I, SRC_DATA_I} = '0;
    {GEN_SOFT_RESET_I, SRC_VALID_I} = '0;
    {mismatches, n_tests} = '0;
    void'($urandom(98278));
    repeat (12) @(posedge REF_CLK_I);
    #1 ARST_N_I = 1'b1;
    GEN_SOFT_RESET_I = 1'b1;
    tick();
    GEN_SOFT_RESET_I = 1'b0;
    csr(OFF_CONTROL, 1, CTL_RST);
    cmd(OFF_INJ, 1, 32'h0);
    csr(OFF_STATUS, 0, ST);
    csr(OFF_CONTROL, 0, CTL_RST);
    csr(OFF_FAULT, 0, 32'h0);
    for (int a = 2; a < 5; a++) csr(3'(a), 0, 32'h0);
    csr(OFF_STATUS, 1, '1);
    csr(OFF_CONTROL, 1, '1);
    csr(OFF_CONTROL, 0, 32'h0003_ff01);
    csr(OFF_STATUS, 0, ST);
    rpt("map");
    csr(OFF_CONTROL, 1, 32'h0001_0001);
    put(32'h0001_0203, 2'h1, 2'b10, 8'h0);
    put(32'h0405_0607, 2'h1, 2'b01, 8'h0);
    csr(OFF_SELECT, 1, 32'hffff_ff01);
    csr(OFF_SELECT, 0, 32'h1);
    csr(OFF_TALLY, 0, {16'd8, 16'd1});
    csr(OFF_FAULT, 0, 32'h0);
    r = 8'($urandom);
    put({r, r + 8'h5, r + 8'h2, r + 8'h3}, 2'h2, 2'b11, 8'h3c);
    csr(OFF_FAULT, 0, {8'h2, 8'h0, 8'h3c, 8'h1});
    csr(OFF_FAULT, 0, 32'h0);
    csr(OFF_SELECT, 1, 32'h2);
    csr(OFF_SELECT, 0, {16'd1, 16'h2});
    csr(OFF_TALLY, 0, {16'd4, 16'd1});
    rpt("stream");
    csr(OFF_SELECT, 1, 32'h1);
    for (int k = 0; k < 2; k++) begin
      csr(OFF_CONTROL, 1, k ? 32'h0000_0001 : 32'h0001_0000);
      put(32'h0809_0a0b + 32'h0404_0404 * k, 2'h1, 2'b00, 8'h0);
      csr(OFF_TALLY, 0, {16'd8, 16'd1});
    end
    csr(OFF_CONTROL, 1, 32'h0001_0001);
    repeat (6) tick();
    csr(OFF_TALLY, 0, {16'd16, 16'd1});
    csr(OFF_CONTROL, 1, 32'h0003_0001);
    csr(OFF_TALLY, 0, 32'h0);
    csr(OFF_CONTROL, 1, 32'h0001_0001);
    put(32'h0001_0203, 2'h1, 2'b11, 8'h0);
    csr(OFF_TALLY, 0, {16'd4, 16'd1});
    csr(OFF_FAULT, 0, 32'h0);
    csr(OFF_CONTROL, 1, 32'h0000_8001);
    src.send('{32'h0405_06ff, 2'h1, 1'b0, 1'b1, 2'h1, 8'h0}, ok);
    lim(ok ? 0 : 64);
    repeat (20) tick();
    csr(OFF_TALLY, 0, {16'd7, 16'd2});
    csr(OFF_SELECT, 0, 32'h1);
    csr(OFF_FAULT, 0, 32'h0);
    rpt("gating");
    for (int h = 1; h < 3; h++) begin
      inj = {6'h0, 2'(h), 8'($urandom), 16'($urandom)};
      cmd(OFF_INJ, 1, inj);
      cmd(OFF_SEG, 1, {2'b11, 14'h3, 16'd8});
      for (int i = 0; i < 2; i++) begin
        d = $urandom;
        tq.push_back({d ^ {4{inj[23:16]}}, i == 0 && h == 2,
                      i == 1 && h == 1, inj[15:0], 14'h3});
        SRC_DATA_I = d;
        SRC_VALID_I = 1'b1;
        n = 0;
        do begin
          @(posedge REF_CLK_I);
          n++;
        end while (!SRC_READY_O && n < 64);
        lim(n);
        #1;
      end
      SRC_VALID_I = 1'b0;
      for (n = 0; tq.size() > 0 && n < 64; n++) tick();
      lim(n);
      cmd(OFF_SEG, 1, {2'b01, 14'h2, 16'd4});
      chk("busy", 64'(1'b1), 64'(CMD_BUSY_O));
      GEN_SOFT_RESET_I = 1'b1;
      tick();
      GEN_SOFT_RESET_I = 1'b0;
      chk("busy", 64'(1'b0), 64'({CMD_BUSY_O, SRC_READY_O}));
      cmd(OFF_INJ, 0, inj);
      cmd(OFF_SEG, 0, {2'b01, 14'h2, 16'd4});
    end
    rpt("generator");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
